// [logic/epmc_mode_control.sv]
// Test and emulation pin mode control: scan hand-over, emulator lines, output float
// Operation
// - Test reset high hands control of the device to the scan system.
// - Test reset low or open keeps the device in functional mode and ignores test resets.
// - With test reset high, emulator line zero is a two-way interrupt line whose direction scan sets.
// - With test reset high, emulator line one is a two-way interrupt line whose direction scan sets.
// - With test reset low, emulator line one is the active-low global output-disable input.
// - While output disable is active, every output driver floats.
// - The test data output floats while output disable is active.
`timescale 1ns/1ps
`include "epmc_params.svh"

module epmc_mode_control (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic testResetPin,
    input wire logic emulator_line_zero_in,
    output logic emulator_line_zero_out,
    output logic emulator_line_zero_oe,
    input wire logic emulator_line_one_or_float_in,
    output logic emulator_line_one_or_float_out,
    output logic emulator_line_one_or_float_oe,
    input wire logic scanDirZero,
    input wire logic scanDirOne,
    input wire logic intrToEmuZero,
    input wire logic intrToEmuOne,
    input wire logic tapTdoData,
    input wire logic tapTdoEnable,
    input wire logic [`EPMC_PAD_W-1:0] coreOutData,
    input wire logic [`EPMC_PAD_W-1:0] coreOutEnable,
    output logic tdoOut,
    output logic tdoOe,
    output logic [`EPMC_PAD_W-1:0] padOut,
    output logic [`EPMC_PAD_W-1:0] padOe,
    output logic scanControl,
    output logic intrFromEmuZero,
    output logic intrFromEmuOne,
    output logic outputsFloating
);

    epmc_pin_if pins ();

    epmc_pkg::epmc_mode_t mode;
    epmc_pkg::epmc_mode_t next_mode;
    logic next_scanControl;
    logic zeroOeReg;
    logic oneOeReg;
    logic next_zeroOeReg;
    logic next_oneOeReg;
    logic next_zeroOut;
    logic next_oneOut;
    logic next_intrFromEmuZero;
    logic next_intrFromEmuOne;
    logic tdoDataReg;
    logic tdoEnReg;
    logic next_tdoDataReg;
    logic next_tdoEnReg;
    logic [`EPMC_PAD_W-1:0] padOeReg;
    logic [`EPMC_PAD_W-1:0] next_padOut;
    logic [`EPMC_PAD_W-1:0] next_padOeReg;
    logic next_outputsFloating;

    // ---------------------------------------------------------------
    // Pin decode
    // ---------------------------------------------------------------
    assign pins.testResetRaw = testResetPin;
    assign pins.emuZeroRaw = emulator_line_zero_in;
    assign pins.emuOneRaw = emulator_line_one_or_float_in;

    epmc_pin_decode u_decode (
        .sys_clk(sys_clk),
        .rst(rst),
        .pins(pins)
    );

    // ---------------------------------------------------------------
    // Mode selection
    // ---------------------------------------------------------------
    // Mode follows the synchronised test reset level
    always_comb begin
        next_mode = mode;
        unique case (mode)
            epmc_pkg::EPMC_FUNCTIONAL: begin
                if (pins.testResetSync) begin
                    next_mode = epmc_pkg::EPMC_SCAN;
                end
            end
            epmc_pkg::EPMC_SCAN: begin
                if (!pins.testResetSync) begin
                    next_mode = epmc_pkg::EPMC_FUNCTIONAL;
                end
            end
        endcase
        next_scanControl = (next_mode == epmc_pkg::EPMC_SCAN);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode <= epmc_pkg::EPMC_FUNCTIONAL;
            scanControl <= `EPMC_BIT_RST;
        end else begin
            mode <= next_mode;
            scanControl <= next_scanControl;
        end
    end

    // ---------------------------------------------------------------
    // Emulator lines
    // ---------------------------------------------------------------
    // Drive or receive per scan direction; in functional mode both are inputs
    always_comb begin
        next_zeroOeReg = pins.testResetSync && scanDirZero;
        next_oneOeReg = pins.testResetSync && scanDirOne;
        next_zeroOut = intrToEmuZero;
        next_oneOut = intrToEmuOne;
        // Received interrupts mean nothing outside scan control
        next_intrFromEmuZero = pins.testResetSync && !scanDirZero && pins.emuZeroSync;
        next_intrFromEmuOne = pins.testResetSync && !scanDirOne && pins.emuOneSync;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            zeroOeReg <= `EPMC_BIT_RST;
            oneOeReg <= `EPMC_BIT_RST;
            emulator_line_zero_out <= `EPMC_BIT_RST;
            emulator_line_one_or_float_out <= `EPMC_BIT_RST;
            intrFromEmuZero <= `EPMC_BIT_RST;
            intrFromEmuOne <= `EPMC_BIT_RST;
        end else begin
            zeroOeReg <= next_zeroOeReg;
            oneOeReg <= next_oneOeReg;
            emulator_line_zero_out <= next_zeroOut;
            emulator_line_one_or_float_out <= next_oneOut;
            intrFromEmuZero <= next_intrFromEmuZero;
            intrFromEmuOne <= next_intrFromEmuOne;
        end
    end

    // Float gating here too, though the decode only fires with test reset low
    assign emulator_line_zero_oe = zeroOeReg && !pins.floatAll;
    assign emulator_line_one_or_float_oe = oneOeReg && !pins.floatAll;

    // ---------------------------------------------------------------
    // Functional pads and test data output
    // ---------------------------------------------------------------
    // Data and enables are registered; the float gate after them is not
    always_comb begin
        next_padOut = coreOutData;
        next_padOeReg = coreOutEnable;
        next_tdoDataReg = tapTdoData;
        next_tdoEnReg = tapTdoEnable;
        next_outputsFloating = pins.floatAll;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            padOut <= `EPMC_PAD_RST;
            padOeReg <= `EPMC_PAD_RST;
            tdoDataReg <= `EPMC_BIT_RST;
            tdoEnReg <= `EPMC_BIT_RST;
            outputsFloating <= `EPMC_BIT_RST;
        end else begin
            padOut <= next_padOut;
            padOeReg <= next_padOeReg;
            tdoDataReg <= next_tdoDataReg;
            tdoEnReg <= next_tdoEnReg;
            outputsFloating <= next_outputsFloating;
        end
    end

    // Clockless gate so a stopped clock cannot hold drivers on
    assign padOe = pins.floatAll ? `EPMC_PAD_RST : padOeReg;
    assign tdoOut = tdoDataReg;
    assign tdoOe = tdoEnReg && !pins.floatAll;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_scan_handover;
        @(posedge sys_clk) disable iff (rst)
        pins.testResetSync |=> scanControl;
    endproperty
    a_scan_handover: assert property (p_scan_handover) else $error("Scan control not taken");

    property p_functional_mode;
        @(posedge sys_clk) disable iff (rst)
        !pins.testResetSync |=> (!scanControl && !intrFromEmuZero && !intrFromEmuOne);
    endproperty
    a_functional_mode: assert property (p_functional_mode) else $error("Functional mode not held");

    property p_zero_direction;
        @(posedge sys_clk) disable iff (rst)
        (pins.testResetSync && !pins.floatAll) ##1 !pins.floatAll |-> emulator_line_zero_oe == $past(scanDirZero);
    endproperty
    a_zero_direction: assert property (p_zero_direction) else $error("Line zero direction wrong");

    property p_zero_receive;
        @(posedge sys_clk) disable iff (rst)
        (pins.testResetSync && !scanDirZero) |=> intrFromEmuZero == $past(pins.emuZeroSync);
    endproperty
    a_zero_receive: assert property (p_zero_receive) else $error("Line zero interrupt lost");

    property p_one_direction;
        @(posedge sys_clk) disable iff (rst)
        (pins.testResetSync && scanDirOne) ##1 !pins.floatAll |-> emulator_line_one_or_float_oe;
    endproperty
    a_one_direction: assert property (p_one_direction) else $error("Line one not driven");

    property p_one_is_input;
        @(posedge sys_clk) disable iff (rst)
        !pins.testResetSync |=> !emulator_line_one_or_float_oe;
    endproperty
    a_one_is_input: assert property (p_one_is_input) else $error("Line one driven in functional mode");

    property p_pads_float;
        @(posedge sys_clk) disable iff (rst)
        pins.floatAll |-> (padOe == `EPMC_PAD_RST && !emulator_line_zero_oe);
    endproperty
    a_pads_float: assert property (p_pads_float) else $error("Pad driven while disabled");

    property p_tdo_float;
        @(posedge sys_clk) disable iff (rst)
        pins.floatAll |-> !tdoOe;
    endproperty
    a_tdo_float: assert property (p_tdo_float) else $error("Test data output driven while disabled");

    property p_recover;
        @(posedge sys_clk) disable iff (rst)
        ($fell(pins.floatAll) && !pins.floatAll) |-> padOe == padOeReg;
    endproperty
    a_recover: assert property (p_recover) else $error("Pads did not recover");

    property p_float_flag;
        @(posedge sys_clk) disable iff (rst)
        pins.floatAll[*2] |-> outputsFloating;
    endproperty
    a_float_flag: assert property (p_float_flag) else $error("Float status missing");

endmodule : epmc_mode_control

// [logic/epmc_params.svh]
// Constants for the emulation pin mode control block
`ifndef EPMC_PARAMS_SVH
`define EPMC_PARAMS_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define EPMC_PAD_W 16
`define EPMC_SYNC_W 2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define EPMC_SYNC_RST 2'h0
`define EPMC_BIT_RST 1'h0
`define EPMC_PAD_RST 16'h0000

`endif

// [logic/epmc_pkg.sv]
// Types shared by the emulation pin mode control modules
package epmc_pkg;

    // Operating mode picked by the test reset pin
    typedef enum logic {
        EPMC_FUNCTIONAL,
        EPMC_SCAN
    } epmc_mode_t;

endpackage : epmc_pkg

// [logic/epmc_pin_if.sv]
// Pin levels and decoded conditions passed between decoder and controller
`timescale 1ns/1ps

interface epmc_pin_if;
    logic testResetRaw;
    logic emuZeroRaw;
    logic emuOneRaw;
    logic testResetSync;
    logic emuZeroSync;
    logic emuOneSync;
    logic floatAll;

    // Decoder owns the syncs and the float decode
    modport decoder (
        input testResetRaw,
        input emuZeroRaw,
        input emuOneRaw,
        output testResetSync,
        output emuZeroSync,
        output emuOneSync,
        output floatAll
    );

    // Controller feeds raw pins and uses the results
    modport ctrl (
        output testResetRaw,
        output emuZeroRaw,
        output emuOneRaw,
        input testResetSync,
        input emuZeroSync,
        input emuOneSync,
        input floatAll
    );
endinterface : epmc_pin_if

// [logic/epmc_pin_decode.sv]
// Pin synchronisers and the asynchronous output-disable decode
`timescale 1ns/1ps
`include "epmc_params.svh"

module epmc_pin_decode (
    input wire logic sys_clk,
    input wire logic rst,
    epmc_pin_if.decoder pins
);

    logic [`EPMC_SYNC_W-1:0] trstStages;
    logic [`EPMC_SYNC_W-1:0] emuZeroStages;
    logic [`EPMC_SYNC_W-1:0] emuOneStages;
    logic [`EPMC_SYNC_W-1:0] next_trstStages;
    logic [`EPMC_SYNC_W-1:0] next_emuZeroStages;
    logic [`EPMC_SYNC_W-1:0] next_emuOneStages;

    // ---------------------------------------------------------------
    // Output-disable decode
    // ---------------------------------------------------------------
    // No clock in this path: pads must float even with the clock stopped
    assign pins.floatAll = !pins.testResetRaw && pins.emuZeroRaw && !pins.emuOneRaw;

    // ---------------------------------------------------------------
    // Two-stage synchronisers
    // ---------------------------------------------------------------
    // Shift each pin in; only stage one reads stage zero
    always_comb begin
        next_trstStages = {trstStages[0], pins.testResetRaw};
        next_emuZeroStages = {emuZeroStages[0], pins.emuZeroRaw};
        next_emuOneStages = {emuOneStages[0], pins.emuOneRaw};
    end

    // Released test reset reads low, as the pulldown leaves it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            trstStages <= `EPMC_SYNC_RST;
            emuZeroStages <= `EPMC_SYNC_RST;
            emuOneStages <= `EPMC_SYNC_RST;
        end else begin
            trstStages <= next_trstStages;
            emuZeroStages <= next_emuZeroStages;
            emuOneStages <= next_emuOneStages;
        end
    end

    assign pins.testResetSync = trstStages[1];
    assign pins.emuZeroSync = emuZeroStages[1];
    assign pins.emuOneSync = emuOneStages[1];

endmodule : epmc_pin_decode

// [tb/epmc_emulator_model.sv]
// Behavioural emulator and tester standing on the far side of the emulation pins
`timescale 1ns/1ps

module epmc_emulator_model (
    input wire logic sys_clk,
    input wire logic devZeroOut,
    input wire logic devZeroOe,
    input wire logic devOneOut,
    input wire logic devOneOe,
    output logic testResetPin,
    output logic lineZero,
    output logic lineOne
);
    logic drvZero = 1'h1;
    logic valZero = 1'h1;
    logic drvOne = 1'h1;
    logic valOne = 1'h1;
    logic idleToggle = 1'h0;

    initial testResetPin = 1'h0;

    // Released line shows a changing pattern, never a stale level
    always @(posedge sys_clk) idleToggle <= ~idleToggle;

    // Wire level: device first, then the emulator, else the idle pattern
    always_comb begin
        lineZero = devZeroOe ? devZeroOut : (drvZero ? valZero : idleToggle);
        lineOne = devOneOe ? devOneOut : (drvOne ? valOne : idleToggle);
    end

    // Caller invokes this just after a rising edge; levels then hold
    // Float request is test reset low, line zero high, line one low
    task automatic set_pins(input logic trst, input logic dz, input logic vz, input logic d1, input logic v1);
        testResetPin = trst;
        drvZero = dz;
        valZero = vz;
        drvOne = d1;
        valOne = v1;
    endtask : set_pins
endmodule : epmc_emulator_model

// [tb/emulation_pin_mode_control_tb_top.sv]
// Self-checking bench for the emulation pin mode control block
`timescale 1ns/1ps
`include "epmc_params.svh"

module emulation_pin_mode_control_tb_top;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic scanDirZero = 1'h0, scanDirOne = 1'h0, intrToEmuZero = 1'h0, intrToEmuOne = 1'h0;
    logic tapTdoData = 1'h0, tapTdoEnable = 1'h0;
    logic [`EPMC_PAD_W-1:0] coreOutData = 16'h0000, coreOutEnable = 16'h0000;
    logic testResetPin, lineZero, lineOne, zeroOut, zeroOe, oneOut, oneOe;
    logic tdoOut, tdoOe, scanControl, intrFromEmuZero, intrFromEmuOne, outputsFloating;
    logic [`EPMC_PAD_W-1:0] padOut, padOe;
    logic [31:0] rnd;
    int seed = 94;
    int miscompares = 0;
    int checked = 0;

    always #25 sys_clk = ~sys_clk;

    epmc_mode_control uut (.sys_clk(sys_clk), .rst(rst), .testResetPin(testResetPin),
        .emulator_line_zero_in(lineZero), .emulator_line_zero_out(zeroOut), .emulator_line_zero_oe(zeroOe),
        .emulator_line_one_or_float_in(lineOne), .emulator_line_one_or_float_out(oneOut),
        .emulator_line_one_or_float_oe(oneOe), .scanDirZero(scanDirZero), .scanDirOne(scanDirOne),
        .intrToEmuZero(intrToEmuZero), .intrToEmuOne(intrToEmuOne), .tapTdoData(tapTdoData),
        .tapTdoEnable(tapTdoEnable), .coreOutData(coreOutData), .coreOutEnable(coreOutEnable),
        .tdoOut(tdoOut), .tdoOe(tdoOe), .padOut(padOut), .padOe(padOe), .scanControl(scanControl),
        .intrFromEmuZero(intrFromEmuZero), .intrFromEmuOne(intrFromEmuOne), .outputsFloating(outputsFloating));

    epmc_emulator_model emu (.sys_clk(sys_clk), .devZeroOut(zeroOut), .devZeroOe(zeroOe),
        .devOneOut(oneOut), .devOneOe(oneOe), .testResetPin(testResetPin), .lineZero(lineZero),
        .lineOne(lineOne));

    // ---------------------------------------------------------------
    // Expectations and comparisons
    // ---------------------------------------------------------------
    function automatic logic exp_float(input logic t, input logic z, input logic o);
        return !t && z && !o;
    endfunction : exp_float

    function automatic logic [15:0] exp_oe(input logic [15:0] en, input logic fl);
        return fl ? 16'h0000 : en;
    endfunction : exp_oe

    task automatic check_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_vec

    // Drive point sits 2 ns after each rising edge; outputs are settled there
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(5);
        rst = 1'h0;
        check_vec(padOe, 16'h0000, "padOe after reset");
        check_bit(scanControl, 1'h0, "scanControl after reset");
        // Functional mode: scan direction and line inputs must be ignored
        for (int i = 0; i < 24; i++) begin
            rnd = $random(seed);
            coreOutEnable = rnd[15:0];
            coreOutData = rnd[31:16];
            rnd = $random(seed);
            {scanDirZero, scanDirOne, intrToEmuZero, intrToEmuOne, tapTdoData, tapTdoEnable} = rnd[5:0];
            if (i == 0) coreOutEnable = 16'hFFFF;
            tick(1);
            check_vec(padOe, coreOutEnable, "functional padOe");
            check_vec(padOut, coreOutData, "functional padOut");
            check_bit(tdoOe, tapTdoEnable, "functional tdoOe");
            check_bit(tdoOut, tapTdoData, "functional tdoOut");
            check_bit(intrFromEmuZero, 1'h0, "line zero interrupt in functional");
            check_bit(zeroOe, 1'h0, "line zero oe in functional");
            check_bit(oneOe, 1'h0, "line one oe in functional");
            check_bit(intrFromEmuOne, 1'h0, "received interrupt in functional");
            check_bit(scanControl, 1'h0, "scanControl in functional");
        end
        $display("Test functional done");
        // Every pin combination, float checked before any clock edge
        coreOutEnable = 16'hFFFF;
        tapTdoEnable = 1'h1;
        scanDirZero = 1'h0;
        scanDirOne = 1'h0;
        tick(1);
        for (int c = 0; c < 8; c++) begin
            emu.set_pins(c[2], 1'h1, c[1], 1'h1, c[0]);
            #1;
            check_vec(padOe, exp_oe(16'hFFFF, exp_float(c[2], c[1], c[0])), "async pad float");
            check_bit(tdoOe, !exp_float(c[2], c[1], c[0]), "test data float");
            tick(1);
            check_bit(outputsFloating, exp_float(c[2], c[1], c[0]), "float status");
            check_vec(padOe, exp_oe(16'hFFFF, exp_float(c[2], c[1], c[0])), "pads float");
            // Hold the levels a second edge so the status flag sees a steady request
            tick(1);
            check_bit(outputsFloating, exp_float(c[2], c[1], c[0]), "float status held");
        end
        emu.set_pins(1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        tick(3);
        $display("Test float done");
        // Scan mode: device drives line zero, emulator drives line one
        scanDirZero = 1'h1;
        intrToEmuZero = 1'h1;
        emu.set_pins(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
        tick(2);
        check_bit(scanControl, 1'h0, "scanControl before sync");
        tick(1);
        check_bit(scanControl, 1'h1, "scanControl");
        check_bit(zeroOe, 1'h1, "line zero driven");
        check_bit(oneOe, 1'h0, "line one released");
        check_bit(outputsFloating, 1'h0, "no float in scan");
        check_vec(padOe, 16'hFFFF, "pads live in scan");
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            intrToEmuZero = rnd[0];
            emu.set_pins(1'h1, 1'h0, 1'h0, 1'h1, rnd[1]);
            tick(3);
            check_bit(zeroOut, rnd[0], "interrupt to emulator");
            check_bit(intrFromEmuOne, rnd[1], "interrupt from emulator");
        end
        // Swap directions: release line zero, device takes line one
        scanDirOne = 1'h1;
        intrToEmuOne = 1'h1;
        emu.set_pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        tick(1);
        scanDirZero = 1'h0;
        tick(1);
        emu.set_pins(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
        tick(3);
        check_bit(oneOe, 1'h1, "line one driven");
        check_bit(oneOut, 1'h1, "line one interrupt out");
        check_bit(zeroOe, 1'h0, "line zero released");
        check_bit(intrFromEmuZero, 1'h1, "line zero interrupt in");
        emu.set_pins(1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        tick(3);
        check_bit(scanControl, 1'h0, "back to functional");
        check_bit(oneOe, 1'h0, "line one released in functional");
        $display("Test scan done");
        // Mid-run reset: registers clear at once, then reload on the first edge after release
        rst = 1'h1;
        #1;
        check_vec(padOe, 16'h0000, "padOe in mid reset");
        check_vec(padOut, 16'h0000, "padOut in mid reset");
        check_bit(tdoOe, 1'h0, "tdoOe in mid reset");
        check_bit(tdoOut, 1'h0, "tdoOut in mid reset");
        check_bit(oneOe, 1'h0, "line one oe in mid reset");
        check_bit(outputsFloating, 1'h0, "float status in mid reset");
        tick(2);
        rst = 1'h0;
        tick(1);
        check_vec(padOe, 16'hFFFF, "padOe after mid reset");
        check_bit(tdoOe, 1'h1, "tdoOe after mid reset");
        check_bit(scanControl, 1'h0, "scanControl after mid reset");
        $display("Test reset done");
        final_report();
    end

    // Watchdog: the tests need under a hundred cycles
    initial begin
        #(2000 * 50);
        miscompares++;
        $display("ERROR %0t: watchdog expired", $time);
        final_report();
    end
endmodule : emulation_pin_mode_control_tb_top
